// ### design/tdma_slot_budget.sv
// Slot budget, message packing, parent linking and slot leases of a node
`timescale 1ns/1ns
`default_nettype none
`include "slot_map.svh"
module tdma_slot_budget #(
  parameter int MAX_CHILDREN = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic [7:0] NODE_ROLE_SELECT_I,
  input wire logic RELAY_ENABLE_I,
  input wire logic [7:0] PARENT_NETWORK_ID_I,
  input wire logic [7:0] BACKUP_PARENT_NETWORK_ID_I,
  input wire logic CFG_LOAD_I,
  input wire slot_pkg::cfg_t CFG_I,
  input wire logic BEACON_VALID_I,
  input wire slot_pkg::cfg_t BEACON_CFG_I,
  input wire logic CAND_VALID_I,
  input wire logic [7:0] CAND_NET_ID_I,
  input wire logic CAND_IS_CHILD_I,
  input wire logic PARENT_LOST_I,
  input wire logic HOP_START_I,
  input wire logic [7:0] QUEUED_COUNT_I,
  input wire logic [7:0] MESSAGES_PER_HOP_LIMIT_I,
  input wire logic MSG_VALID_I,
  input wire logic [7:0] MSG_LEN_I,
  input wire logic [7:0] SLOT_RESERVATION_HOPS_I,
  input wire logic [MAX_CHILDREN-1:0] SLOT_ACTIVITY_I,
  output var slot_pkg::cfg_t ACTIVE_CFG_O,
  output logic [7:0] UPLINK_SLOT_SIZE_O,
  output logic [7:0] DL_BUFFER_SIZE_O,
  output logic [7:0] UL_BUFFER_SIZE_O,
  output logic CALC_BUSY_O,
  output logic IS_ROUTER_O,
  output logic RELAY_ACTIVE_O,
  output logic AUTO_PARENT_O,
  output logic BACKUP_ENABLED_O,
  output logic LINKED_O,
  output logic [7:0] PARENT_ID_O,
  output logic MSG_ADMIT_O,
  output logic MSG_DEFER_O,
  output logic MSG_DROP_O,
  output logic [7:0] MSGS_IN_HOP_O,
  output logic [MAX_CHILDREN-1:0] SLOT_RESERVED_O
);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (MAX_CHILDREN != 8) begin : g_bad_children
    $error("slot lease logic serves exactly eight child slots");
  end
  // Assertions all sample on the system clock and rest during reset
  default clocking cb_sys @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // ----------------------------------------------------------------------
  // Role and topology decode
  // ----------------------------------------------------------------------
  wire is_base, is_router, auto_parent, backup_en;
  assign is_base = (NODE_ROLE_SELECT_I == `ROLE_BASE);
  assign is_router = (NODE_ROLE_SELECT_I == `ROLE_ROUTER);
  assign auto_parent = (PARENT_NETWORK_ID_I == `NET_ID_NONE);
  assign backup_en = (BACKUP_PARENT_NETWORK_ID_I != `NET_ID_NONE);

  // ----------------------------------------------------------------------
  // Configuration source and sanitising
  // ----------------------------------------------------------------------
  // Only the base takes a local load; the rest follow the base's beacon
  wire load_cfg;
  slot_pkg::cfg_t src_cfg;
  wire [3:0] slots_clamped, slots_m1;
  wire [7:0] dl_ceiling, dl_clamped;
  assign load_cfg = is_base ? CFG_LOAD_I : BEACON_VALID_I;
  assign src_cfg = is_base ? CFG_I : BEACON_CFG_I;
  assign slots_clamped = (src_cfg.slot_count < `SLOTS_MIN) ? `SLOTS_MIN :
                         (src_cfg.slot_count > `SLOTS_MAX) ? `SLOTS_MAX :
                         src_cfg.slot_count;
  assign slots_m1 = slots_clamped - 4'h1;
  assign dl_ceiling = `DL_MAX_ONE_SLOT -
                      (`DL_STEP_PER_SLOT * {4'h0, slots_m1});
  assign dl_clamped = (src_cfg.dl_size > dl_ceiling) ? dl_ceiling :
                      src_cfg.dl_size;

  slot_pkg::cfg_t cfg_reg, cfg_next;
  assign cfg_next = '{dl_size: dl_clamped, slot_count: slots_clamped,
                      hop_us: src_cfg.hop_us};

  // ----------------------------------------------------------------------
  // Uplink slot size calculation
  // ----------------------------------------------------------------------
  slot_pkg::calc_state_t state_reg, state_next;
  logic [7:0] ul_size_reg;
  wire div_done, div_start, in_round, in_uplink;
  wire [17:0] div_q, div_dividend, div_divisor, round_dividend;
  wire [17:0] hop_eff_now, fixed_us, budget_us, per_byte_us;
  wire [7:0] ul_capped;

  assign in_round = (state_reg == slot_pkg::CALC_ROUND);
  assign in_uplink = (state_reg == slot_pkg::CALC_UPLINK);
  // Adding 499 before dividing by 500 rounds the hop time upward
  assign round_dividend = {1'b0, cfg_next.hop_us} + `HOP_ROUND_ADD_US;
  assign hop_eff_now = div_q * `HOP_STEP_US;
  // Everything in the hop except the uplink payload bytes
  assign fixed_us = (`BYTE_COST_US * {10'h000, cfg_reg.dl_size}) +
                    `FIXED_COST_US +
                    (`SLOT_COST_US * {14'h0000, cfg_reg.slot_count});
  // A hop too short for the fixed part leaves no uplink payload at all
  assign budget_us = (hop_eff_now > fixed_us) ?
                     hop_eff_now - fixed_us : 18'h00000;
  assign per_byte_us = `BYTE_COST_US * {14'h0000, cfg_reg.slot_count};
  assign div_start = load_cfg | (in_round & div_done);
  assign div_dividend = load_cfg ? round_dividend : budget_us;
  assign div_divisor = load_cfg ? `HOP_STEP_US : per_byte_us;
  assign ul_capped = (div_q > {10'h000, `UL_MAX}) ? `UL_MAX :
                     div_q[7:0];

  // A new load restarts the sequence even mid-calculation
  always_comb begin
    state_next = state_reg;
    if (load_cfg) begin
      state_next = slot_pkg::CALC_ROUND;
    end else begin
      unique case (state_reg)
        slot_pkg::CALC_IDLE: state_next = slot_pkg::CALC_IDLE;
        slot_pkg::CALC_ROUND: begin
          if (div_done) begin
            state_next = slot_pkg::CALC_UPLINK;
          end
        end
        slot_pkg::CALC_UPLINK: begin
          if (div_done) begin
            state_next = slot_pkg::CALC_IDLE;
          end
        end
        default: state_next = slot_pkg::CALC_IDLE;
      endcase
    end
  end

  slot_divider #(.W(18)) u_div (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .start_i(div_start),
    .dividend_i(div_dividend),
    .divisor_i(div_divisor),
    .done_o(div_done),
    .quotient_o(div_q)
  );

  // Configuration and calculation results; defaults give a 25-byte uplink
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cfg_reg <= '{dl_size: `DL_SIZE_RST, slot_count: `SLOTS_RST,
                   hop_us: `HOP_US_RST};
      ul_size_reg <= `UL_SIZE_RST;
      state_reg <= slot_pkg::CALC_IDLE;
    end else begin
      state_reg <= state_next;
      if (load_cfg) begin
        cfg_reg <= cfg_next;
      end
      if (in_uplink & div_done & !load_cfg) begin
        ul_size_reg <= ul_capped;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Buffer sizes and status outputs
  // ----------------------------------------------------------------------
  wire [7:0] dl_buf_raw, ul_buf_raw;
  wire [7:0] dl_buf, ul_buf;
  assign dl_buf_raw = cfg_reg.dl_size + `HDR_BYTES;
  assign ul_buf_raw = ul_size_reg + `HDR_BYTES;
  assign dl_buf = (dl_buf_raw > `DL_BUF_MAX) ? `DL_BUF_MAX :
                  dl_buf_raw;
  assign ul_buf = (ul_buf_raw > `UL_BUF_MAX) ? `UL_BUF_MAX :
                  ul_buf_raw;

  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ACTIVE_CFG_O <= '{dl_size: `DL_SIZE_RST, slot_count: `SLOTS_RST,
                        hop_us: `HOP_US_RST};
      UPLINK_SLOT_SIZE_O <= `UL_SIZE_RST;
      DL_BUFFER_SIZE_O <= `DL_SIZE_RST + `HDR_BYTES;
      UL_BUFFER_SIZE_O <= `UL_SIZE_RST + `HDR_BYTES;
      CALC_BUSY_O <= 1'b0;
      IS_ROUTER_O <= 1'b0;
      RELAY_ACTIVE_O <= 1'b0;
      AUTO_PARENT_O <= 1'b0;
      BACKUP_ENABLED_O <= 1'b0;
    end else begin
      ACTIVE_CFG_O <= cfg_reg;
      UPLINK_SLOT_SIZE_O <= ul_size_reg;
      DL_BUFFER_SIZE_O <= dl_buf;
      UL_BUFFER_SIZE_O <= ul_buf;
      CALC_BUSY_O <= (state_next != slot_pkg::CALC_IDLE);
      IS_ROUTER_O <= is_router;
      // Relaying needs the enable even in routers
      RELAY_ACTIVE_O <= is_router & RELAY_ENABLE_I;
      AUTO_PARENT_O <= auto_parent & !is_base;
      BACKUP_ENABLED_O <= backup_en & !auto_parent & !is_base;
    end
  end

  // ----------------------------------------------------------------------
  // Parent linking
  // ----------------------------------------------------------------------
  logic on_backup_reg;
  wire primary_match, backup_match, accept;
  assign primary_match = (CAND_NET_ID_I == PARENT_NETWORK_ID_I);
  assign backup_match = on_backup_reg &
                        (CAND_NET_ID_I == BACKUP_PARENT_NETWORK_ID_I);
  // Our own child routers are never taken as parent
  assign accept = !is_base & CAND_VALID_I & !LINKED_O & !CAND_IS_CHILD_I &
                  (auto_parent | primary_match | backup_match);

  // Loss beats a candidate seen in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      LINKED_O <= 1'b0;
      PARENT_ID_O <= `NET_ID_NONE;
      on_backup_reg <= 1'b0;
    end else if (PARENT_LOST_I | is_base) begin
      LINKED_O <= 1'b0;
      on_backup_reg <= !auto_parent & backup_en & !is_base;
    end else if (accept) begin
      LINKED_O <= 1'b1;
      PARENT_ID_O <= CAND_NET_ID_I;
      if (primary_match) begin
        on_backup_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Message packing per hop
  // ----------------------------------------------------------------------
  logic [8:0] remain_reg;
  logic [7:0] eligible_reg;
  wire [7:0] own_buf;
  wire [8:0] msg_cost;
  wire fits_whole, fits_now, room;
  assign own_buf = is_base ? dl_buf : ul_buf;
  assign msg_cost = {1'b0, MSG_LEN_I} + {1'b0, `HDR_BYTES};
  // A message that can never fit is dropped rather than split
  assign fits_whole = (msg_cost <= {1'b0, own_buf});
  assign fits_now = (msg_cost <= remain_reg);
  assign room = (MSGS_IN_HOP_O < MESSAGES_PER_HOP_LIMIT_I) &
                (MSGS_IN_HOP_O < eligible_reg);

  // A message offered in the hop-start cycle waits for the next hop
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      remain_reg <= 9'h000;
      eligible_reg <= 8'h00;
      MSGS_IN_HOP_O <= 8'h00;
      MSG_ADMIT_O <= 1'b0;
      MSG_DEFER_O <= 1'b0;
      MSG_DROP_O <= 1'b0;
    end else if (HOP_START_I) begin
      remain_reg <= {1'b0, own_buf};
      eligible_reg <= QUEUED_COUNT_I;
      MSGS_IN_HOP_O <= 8'h00;
      MSG_ADMIT_O <= 1'b0;
      MSG_DEFER_O <= MSG_VALID_I;
      MSG_DROP_O <= 1'b0;
    end else begin
      MSG_ADMIT_O <= MSG_VALID_I & fits_whole & fits_now & room;
      MSG_DEFER_O <= MSG_VALID_I & fits_whole & !(fits_now & room);
      MSG_DROP_O <= MSG_VALID_I & !fits_whole;
      if (MSG_VALID_I & fits_whole & fits_now & room) begin
        remain_reg <= remain_reg - msg_cost;
        MSGS_IN_HOP_O <= MSGS_IN_HOP_O + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Slot leases, one per child slot
  // ----------------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < MAX_CHILDREN; gi++) begin : g_lease
    logic [7:0] gap_reg;
    wire slot_used;
    wire [7:0] gap_next;
    assign slot_used = is_base & (4'(gi) < cfg_reg.slot_count);
    assign gap_next = gap_reg + 8'h01;
    // Activity wins over a hop boundary in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
        gap_reg <= 8'h00;
        SLOT_RESERVED_O[gi] <= 1'b0;
      end else if (!slot_used) begin
        gap_reg <= 8'h00;
        SLOT_RESERVED_O[gi] <= 1'b0;
      end else if (SLOT_ACTIVITY_I[gi]) begin
        gap_reg <= 8'h00;
        SLOT_RESERVED_O[gi] <= 1'b1;
      end else if (HOP_START_I & SLOT_RESERVED_O[gi]) begin
        gap_reg <= gap_next;
        if (gap_next >= SLOT_RESERVATION_HOPS_I) begin
          SLOT_RESERVED_O[gi] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_relay_router;
    RELAY_ACTIVE_O |-> IS_ROUTER_O;
  endproperty
  a_relay_router: assert property (p_relay_router)
    else $error("relay active on a node that is not a router");
  property p_dl_ceiling;
    ACTIVE_CFG_O.dl_size <=
      8'(8'h6C - 8'h03 * {4'h0, ACTIVE_CFG_O.slot_count});
  endproperty
  a_dl_ceiling: assert property (p_dl_ceiling)
    else $error("downlink slot size above its ceiling");
  property p_dl_buf;
    DL_BUFFER_SIZE_O == 8'(ACTIVE_CFG_O.dl_size + 8'h09);
  endproperty
  a_dl_buf: assert property (p_dl_buf)
    else $error("downlink buffer is not slot size plus nine");
  property p_ul_limits;
    (UPLINK_SLOT_SIZE_O <= 8'h6D) && (UL_BUFFER_SIZE_O <= 8'h76);
  endproperty
  a_ul_limits: assert property (p_ul_limits)
    else $error("uplink size or buffer above limit");
  property p_admit_limit;
    MSG_ADMIT_O |-> (MSGS_IN_HOP_O <= $past(MESSAGES_PER_HOP_LIMIT_I)) &&
                    (MSGS_IN_HOP_O <= eligible_reg);
  endproperty
  a_admit_limit: assert property (p_admit_limit)
    else $error("more messages in hop than allowed");
  property p_admit_whole;
    MSG_ADMIT_O |-> $past(msg_cost) <= {1'b0, $past(own_buf)};
  endproperty
  a_admit_whole: assert property (p_admit_whole)
    else $error("admitted message larger than the buffer");
  property p_calc_ends;
    $rose(CALC_BUSY_O) |-> ##[1:45] !CALC_BUSY_O || load_cfg;
  endproperty
  a_calc_ends: assert property (p_calc_ends)
    else $error("uplink calculation did not finish in time");
  property p_no_child_parent;
    $rose(LINKED_O) |-> !$past(CAND_IS_CHILD_I);
  endproperty
  a_no_child_parent: assert property (p_no_child_parent)
    else $error("linked to one of its own child routers");
  property p_lost_unlinks;
    PARENT_LOST_I |=> !LINKED_O;
  endproperty
  a_lost_unlinks: assert property (p_lost_unlinks)
    else $error("still linked after parent loss");
  property p_slots_in_range;
    (SLOT_RESERVED_O >> ACTIVE_CFG_O.slot_count) == '0;
  endproperty
  a_slots_in_range: assert property (p_slots_in_range)
    else $error("slot reserved beyond the slot count");
endmodule
`default_nettype wire

// ### shared/slot_map.svh
// Constants for the TDMA slot budget and relay configuration block
`ifndef SLOT_MAP_SVH
`define SLOT_MAP_SVH

// ----------------------------------------------------------------------
// Roles and identifiers
// ----------------------------------------------------------------------
`define ROLE_BASE 8'h01
`define ROLE_ROUTER 8'h02
`define NET_ID_NONE 8'hFF

// ----------------------------------------------------------------------
// Slot and buffer limits in bytes, and slot count limits
// ----------------------------------------------------------------------
`define DL_MAX_ONE_SLOT 8'h69
`define DL_STEP_PER_SLOT 8'h03
`define HDR_BYTES 8'h09
`define DL_BUF_MAX 8'h72
`define UL_MAX 8'h6D
`define UL_BUF_MAX 8'h76
`define SLOTS_MIN 4'h1
`define SLOTS_MAX 4'h8

// ----------------------------------------------------------------------
// Hop timing terms in microseconds
// ----------------------------------------------------------------------
`define BYTE_COST_US 18'h00050
`define SLOT_COST_US 18'h00988
`define FIXED_COST_US 18'h00CD0
`define HOP_STEP_US 18'h001F4
`define HOP_ROUND_ADD_US 18'h001F3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DL_SIZE_RST 8'h28
`define SLOTS_RST 4'h3
`define HOP_US_RST 17'h04E20
`define UL_SIZE_RST 8'h19

`endif

// ### shared/slot_pkg.sv
// Types shared by the slot budget block
package slot_pkg;

  // Network-wide hop configuration, as loaded or as adopted from the base
  typedef struct packed {
    logic [7:0] dl_size;
    logic [3:0] slot_count;
    logic [16:0] hop_us;
  } cfg_t;

  // Uplink size calculation sequence
  typedef enum logic [2:0] {
    CALC_IDLE = 3'b001,
    CALC_ROUND = 3'b010,
    CALC_UPLINK = 3'b100
  } calc_state_t;

endpackage

// ### design/slot_divider.sv
// Iterative restoring divider used for hop rounding and uplink sizing
`timescale 1ns/1ns
`default_nettype none
module slot_divider #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  output logic done_o,
  output logic [W-1:0] quotient_o
);

  localparam int CW = $clog2(W + 1);

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (W < 2) begin : g_bad_width
    $error("slot_divider needs W of at least 2");
  end

  logic [W-1:0] rem_reg;
  logic [W-1:0] quo_reg;
  logic [W-1:0] div_reg;
  logic [CW-1:0] cnt_reg;
  logic done_reg;
  logic [W-1:0] shifted;
  logic take;

  // One quotient bit per cycle; a new start simply restarts
  assign shifted = {rem_reg[W-2:0], quo_reg[W-1]};
  assign take = (shifted >= div_reg);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rem_reg <= '0;
      quo_reg <= '0;
      div_reg <= '0;
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else if (start_i) begin
      rem_reg <= '0;
      quo_reg <= dividend_i;
      div_reg <= divisor_i;
      cnt_reg <= CW'(W);
      done_reg <= 1'b0;
    end else if (cnt_reg != '0) begin
      rem_reg <= take ? shifted - div_reg : shifted;
      quo_reg <= {quo_reg[W-2:0], take};
      cnt_reg <= cnt_reg - 1'b1;
      done_reg <= (cnt_reg == CW'(1));
    end else begin
      done_reg <= 1'b0;
    end
  end

  assign done_o = done_reg;
  assign quotient_o = quo_reg;

endmodule
`default_nettype wire

// ### tb/radio_peer_model.sv
// Model of the neighbouring radios: base beacons and parent candidates
`timescale 1ns/1ns
`default_nettype none
module radio_peer_model (
  input wire logic clk_i,
  output var logic bv_o,
  output var slot_pkg::cfg_t bcfg_o,
  output var logic cv_o,
  output var logic [7:0] cid_o,
  output var logic cchild_o,
  output var logic lost_o
);
  // ------------------------------------------------------------------
  // Peer traffic, launched at falling edges
  // ------------------------------------------------------------------
  // Quiet at start
  initial begin
    {bv_o, cv_o, cchild_o, lost_o} = 4'h0;
    bcfg_o = '0;
    cid_o = 8'h00;
  end
  // Base sends its hop setup to every child
  task automatic beacon(input slot_pkg::cfg_t c);
    @(negedge clk_i);
    bv_o = 1'b1;
    bcfg_o = c;
    @(negedge clk_i);
    bv_o = 1'b0;
    bcfg_o = ~c; // Stale data not held
  endtask
  // Routers announce their own distinct ids
  task automatic announce(input logic [7:0] id, input logic child);
    @(negedge clk_i);
    {cv_o, cchild_o, cid_o} = {1'b1, child, id};
    @(negedge clk_i);
    {cv_o, cchild_o, cid_o} = {1'b0, ~child, ~id};
  endtask
  // Parent router drops out
  task automatic fail();
    @(negedge clk_i);
    lost_o = 1'b1;
    @(negedge clk_i);
    lost_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/tb_tdma_slot_budget.sv
// Self-checking bench for the slot budget and relay block
`timescale 1ns/1ns
`default_nettype none
module tb_tdma_slot_budget;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] role = 8'h01;
  logic relay = 1'b1; // Relaying on in all radios
  logic [7:0] par = 8'hFF;
  logic [7:0] bkp = 8'hFF;
  logic load = 1'b0;
  logic hop = 1'b0;
  logic mv = 1'b0;
  logic [7:0] queued = 8'h03;
  logic [7:0] limit = 8'h02;
  logic [7:0] mlen = 8'h00;
  logic [7:0] lease = 8'h02;
  logic [7:0] act = 8'h00;
  slot_pkg::cfg_t cfg = '0;
  slot_pkg::cfg_t bcfg, acfg;
  logic bv, cv, cc, lost, busy, rtr, ract, autp, bken, lnk, adm, dfr, drp;
  logic [7:0] cid, ul, dlb, ulb, pid, nmsg, rsv;
  int fails = 0;
  int num_checks = 0;
  // ------------------------------------------------------------------
  // Clock, block and peer
  // ------------------------------------------------------------------
  always #4 clk = ~clk;
  tdma_slot_budget u_dut (.SYS_CLK_I(clk), .RSTN_I(rstn),
    .NODE_ROLE_SELECT_I(role), .RELAY_ENABLE_I(relay),
    .PARENT_NETWORK_ID_I(par), .BACKUP_PARENT_NETWORK_ID_I(bkp),
    .CFG_LOAD_I(load), .CFG_I(cfg), .BEACON_VALID_I(bv),
    .BEACON_CFG_I(bcfg), .CAND_VALID_I(cv), .CAND_NET_ID_I(cid),
    .CAND_IS_CHILD_I(cc), .PARENT_LOST_I(lost), .HOP_START_I(hop),
    .QUEUED_COUNT_I(queued), .MESSAGES_PER_HOP_LIMIT_I(limit),
    .MSG_VALID_I(mv), .MSG_LEN_I(mlen), .SLOT_RESERVATION_HOPS_I(lease),
    .SLOT_ACTIVITY_I(act), .ACTIVE_CFG_O(acfg), .UPLINK_SLOT_SIZE_O(ul),
    .DL_BUFFER_SIZE_O(dlb), .UL_BUFFER_SIZE_O(ulb), .CALC_BUSY_O(busy),
    .IS_ROUTER_O(rtr), .RELAY_ACTIVE_O(ract), .AUTO_PARENT_O(autp),
    .BACKUP_ENABLED_O(bken), .LINKED_O(lnk), .PARENT_ID_O(pid),
    .MSG_ADMIT_O(adm), .MSG_DEFER_O(dfr), .MSG_DROP_O(drp),
    .MSGS_IN_HOP_O(nmsg), .SLOT_RESERVED_O(rsv));
  radio_peer_model u_peer (.clk_i(clk), .bv_o(bv), .bcfg_o(bcfg),
    .cv_o(cv), .cid_o(cid), .cchild_o(cc), .lost_o(lost));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Busy rises on the same edge that samples the load; one more edge is skipped first
  task automatic wait_calc();
    int n;
    n = 0;
    @(negedge clk);
    while (busy !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      fails++;
      wrap_up();
    end
    repeat (2) @(negedge clk);
  endtask
  // Verdict flag stands for one cycle only
  task automatic offer(input logic [7:0] len, input logic [2:0] exp);
    mlen = len; // Payload length; the header adds nine bytes to its cost
    pulse(mv);
    chk({adm, dfr, drp}, exp);
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk(acfg, {8'd40, 4'd3, 17'd20000});
    chk({ul, dlb, ulb}, {8'd25, 8'd49, 8'd34});
    // Long hop: uplink saturates at its ceiling
    cfg = {8'd96, 4'd4, 17'd55600}; // Slot sizes kept at 20 or more
    pulse(load);
    chk(busy, 1'b1);
    wait_calc();
    chk({ul, ulb, dlb}, {8'd109, 8'd118, 8'd105});
    // Oversized downlink is clamped; odd hop is rounded up
    cfg = {8'd120, 4'd2, 17'd20001};
    pulse(load);
    wait_calc();
    chk(acfg[28:17], {8'd102, 4'd2});
    chk({ul, dlb}, {8'd26, 8'd111});
    // Lease: slot 7 lies past the slot count
    act = 8'h81;
    @(negedge clk);
    act = 8'h00;
    @(negedge clk);
    chk(rsv, 8'h01);
    pulse(hop);
    repeat (2) @(negedge clk);
    chk(rsv, 8'h01);
    pulse(hop);
    repeat (2) @(negedge clk);
    chk(rsv, 8'h00);
    // Router adopts the base's setup, ignores its own load
    role = 8'h02;
    u_peer.beacon({8'd60, 4'd2, 17'd20000});
    wait_calc();
    chk({rtr, ract, autp, bken}, 4'hE);
    chk({ul, ulb}, {8'd44, 8'd53});
    // Enable dropped briefly: a router alone does not relay
    relay = 1'b0;
    repeat (2) @(negedge clk);
    chk(ract, 1'b0);
    relay = 1'b1;
    pulse(load);
    repeat (3) @(negedge clk);
    chk(acfg, {8'd60, 4'd2, 17'd20000});
    // Automatic parent choice
    u_peer.announce(8'h05, 1'b1);
    @(negedge clk);
    chk(lnk, 1'b0);
    u_peer.announce(8'h06, 1'b0);
    @(negedge clk);
    chk({lnk, pid}, {1'b1, 8'h06});
    u_peer.fail();
    @(negedge clk);
    chk(lnk, 1'b0);
    u_peer.announce(8'h07, 1'b0);
    @(negedge clk);
    chk(pid, 8'h07);
    // Manual parent with backup
    par = 8'h03;
    bkp = 8'h04;
    u_peer.fail();
    @(negedge clk);
    chk({lnk, bken}, 2'b01);
    u_peer.announce(8'h09, 1'b0);
    @(negedge clk);
    chk(lnk, 1'b0);
    u_peer.announce(8'h04, 1'b0);
    @(negedge clk);
    chk({lnk, pid}, {1'b1, 8'h04});
    // Packing into a 53-byte buffer, two messages at most
    pulse(hop);
    offer(8'd45, 3'b001);
    offer(8'd20, 3'b100);
    offer(8'd15, 3'b100);
    offer(8'd1, 3'b010);
    chk(nmsg, 8'd2);
    // Only one message was queued before this hop
    queued = 8'h01;
    limit = 8'h08;
    pulse(hop);
    offer(8'd1, 3'b100);
    offer(8'd1, 3'b010);
    wrap_up();
  end
endmodule
`default_nettype wire
